// ==== hw/wfp_pkg.sv ====
// Package for the wake frame pattern filter: register map, fields, reset values
package wfp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MASK_BITS = 128;
	localparam int MASK_WORDS = 4;
	localparam int DA_BYTES = 6;
	localparam int CNT_W = 16;
	// Byte offsets of the registers
	localparam logic [7:0] OFS_WAKE_CSR = 8'h00;
	localparam logic [7:0] OFS_CFG_A = 8'h04;
	localparam logic [7:0] OFS_CFG_B = 8'h08;
	localparam logic [7:0] OFS_MASK0 = 8'h10;
	localparam logic [7:0] OFS_ADDR_A = 8'h20;
	localparam logic [7:0] OFS_ADDR_B = 8'h24;
	localparam logic [7:0] OFS_ADDR_C = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
	localparam logic [7:0] OFS_IRQ_SRC = 8'h30;
	// Wake control/status fields
	localparam int CSR_DETECT_EN_BIT = 0;
	localparam int CSR_FRAME_RX_BIT = 1;
	// Filter configuration A fields
	localparam int CFGA_OFS_LSB = 0;
	localparam int CFGA_OFS_W = 8;
	localparam int CFGA_BCAST_EN_BIT = 24;
	localparam int CFGA_ANY_MC_EN_BIT = 25;
	localparam int CFGA_ADDR_EN_BIT = 26;
	localparam int CFGA_TRIG_BIT = 27;
	localparam int CFGA_FILTER_EN_BIT = 31;
	// Interrupt source/mask wake event bit
	localparam int WAKE_EVENT_BIT = 8;
	// Reset values
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : wfp_pkg

// ==== hw/wfp_crc16.sv ====
// CRC-16 accumulator that folds in selected bytes of a frame
`timescale 1ns/10ps
`default_nettype none
module wfp_crc16 (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic update,
	input wire logic [7:0] data,
	output logic [15:0] crc_q
);
	import wfp_pkg::*;

	logic [15:0] base;
	logic [15:0] next_crc;
	logic [15:0] crc_d;
	logic [7:0] f;

	// A new frame starts from all ones, even on its first byte
	assign base = start ? CRC_INIT : crc_q;

	always_comb begin
		f[0] = base[15] ^ data[0];
		for (int i = 1; i < 8; i++) begin
			f[i] = base[15 - i] ^ f[i - 1] ^ data[i];
		end
		next_crc[15] = base[7] ^ f[7];
		next_crc[14:10] = base[6:2];
		next_crc[9] = base[1] ^ f[0];
		next_crc[8] = base[0] ^ f[1];
		for (int k = 2; k < 8; k++) begin
			next_crc[k] = f[7 - k] ^ f[9 - k];
		end
		next_crc[1] = f[6];
		next_crc[0] = f[7];
	end

	assign crc_d = update ? next_crc : base;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			crc_q <= CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end
endmodule // wfp_crc16
`default_nettype wire

// ==== hw/wfp_filter.sv ====
// Wake frame pattern filter with Avalon-MM register slave
// How it works
// - A 128-bit byte mask, one bit per frame byte, picks checksum bytes.
// - Byte offset+j enters the checksum when mask bit j is set.
// - Offset zero is the first destination address byte.
// - The CRC-16 accumulator starts at all ones on every frame.
// - Only selected bytes change the accumulator; others leave it alone.
// - Intermediates F0..F7 chain accumulator high bits with data bits.
// - New bit 15 is old bit 7 xor F7; bits 14..10 take old bits 6..2.
// - Low accumulator bits follow the fixed F-term xor table.
// - With address matching on, a unicast frame counts only at the programmed address.
// - Specific, any-multicast and broadcast qualifiers are ORed, each enabled alone.
// - Wake needs filter on, CRC equal and one qualifying frame type case.
// - A wake frame must also pass FCS and length checks.
// - Frames are tested only while wake frame detection is enabled.
// - A wake frame sets the received flag and the filter triggered flag.
// - Every wake frame sets the wake event bit of the interrupt source.
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module wfp_filter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [wfp_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [wfp_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [wfp_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic [7:0] rx_data,
	input wire logic rx_eof,
	input wire logic rx_fcs_ok,
	input wire logic rx_len_ok,
	output logic wake_event,
	output logic xcvr_irq
);
	import wfp_pkg::*;

	// Byte-enable merge of a write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Write-one-to-clear on one bit; a set in the same cycle wins
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr);
	endfunction

	// Register state
	logic wake_csr_en_q;
	logic wake_rx_flag_q;
	logic [31:0] cfg_a_q;
	logic trig_flag_q;
	logic [15:0] cfg_b_q;
	logic [MASK_BITS-1:0] mask_q;
	logic [15:0] addr_a_q;
	logic [15:0] addr_b_q;
	logic [15:0] addr_c_q;
	logic irq_mask_q;
	logic irq_src_q;
	logic [31:0] rdata_q;
	logic wait_q;
	logic wake_ev_q;
	logic irq_q;

	// Frame state
	logic in_frame_q;
	logic [CNT_W-1:0] cnt_q;
	logic [7:0] da_q [DA_BYTES];
	logic [15:0] crc_q;

	// Bus decode
	wire [5:0] word_sel = avs_address[7:2];
	// Accepted while waitrequest is high; a write lands on the edge that sees it low
	wire acc = (avs_read | avs_write) & wait_q;
	wire wr_done = avs_write & ~wait_q;
	wire wr_csr = wr_done & (word_sel == OFS_WAKE_CSR[7:2]);
	wire wr_cfga = wr_done & (word_sel == OFS_CFG_A[7:2]);
	wire wr_cfgb = wr_done & (word_sel == OFS_CFG_B[7:2]);
	wire wr_adra = wr_done & (word_sel == OFS_ADDR_A[7:2]);
	wire wr_adrb = wr_done & (word_sel == OFS_ADDR_B[7:2]);
	wire wr_adrc = wr_done & (word_sel == OFS_ADDR_C[7:2]);
	wire wr_imask = wr_done & (word_sel == OFS_IRQ_MASK[7:2]);
	wire wr_isrc = wr_done & (word_sel == OFS_IRQ_SRC[7:2]);
	wire mask_hit = (word_sel >= OFS_MASK0[7:2]) && (word_sel < OFS_MASK0[7:2] + 6'(MASK_WORDS));
	wire [1:0] mask_idx = 2'(word_sel - OFS_MASK0[7:2]);
	wire wr_mask = wr_done & mask_hit;

	// Write-one-to-clear strobes, only where that byte lane is enabled
	wire clr_rx_flag = wr_csr & avs_byteenable[0] & avs_writedata[CSR_FRAME_RX_BIT];
	wire clr_trig = wr_cfga & avs_byteenable[3] & avs_writedata[CFGA_TRIG_BIT];
	wire clr_src = wr_isrc & avs_byteenable[1] & avs_writedata[WAKE_EVENT_BIT];

	// Configuration fields
	wire filter_en = cfg_a_q[CFGA_FILTER_EN_BIT];
	wire addr_en = cfg_a_q[CFGA_ADDR_EN_BIT];
	wire any_mc_en = cfg_a_q[CFGA_ANY_MC_EN_BIT];
	wire bcast_en = cfg_a_q[CFGA_BCAST_EN_BIT];
	wire [CNT_W-1:0] pat_ofs = CNT_W'(cfg_a_q[CFGA_OFS_LSB +: CFGA_OFS_W]);
	wire [47:0] prog_addr = {addr_c_q, addr_b_q, addr_a_q};

	// Byte position in frame; the first byte of a frame is position zero
	wire [CNT_W-1:0] pos = rx_sof ? '0 : cnt_q;
	wire [CNT_W-1:0] rel = pos - pat_ofs;
	wire in_window = (pos >= pat_ofs) && (rel < CNT_W'(MASK_BITS));
	wire byte_sel = in_window && mask_q[rel[6:0]];
	wire byte_ok = rx_valid & (rx_sof | in_frame_q);
	wire crc_upd = byte_ok & byte_sel;
	// Next byte position and destination address capture strobe
	wire [CNT_W-1:0] cnt_nxt = (&pos) ? pos : CNT_W'(pos + 1'b1);
	wire da_cap = byte_ok && (pos < CNT_W'(DA_BYTES));

	// The accumulator reloads on the start byte itself, so no frame leaks into the next
	wfp_crc16 u_crc (
		.core_clk(core_clk),
		.rst(rst),
		.start(rx_valid & rx_sof),
		.update(crc_upd),
		.data(rx_data),
		.crc_q(crc_q)
	);

	// Destination address classification; byte 0 goes first on the wire
	wire [47:0] da_word = {da_q[5], da_q[4], da_q[3], da_q[2], da_q[1], da_q[0]};
	wire is_bcast = &da_word;
	wire is_mcast = da_q[0][0] & ~is_bcast;
	wire is_ucast = ~da_q[0][0];
	wire addr_hit = da_word == prog_addr;
	wire q_ucast = is_ucast & (~addr_en | addr_hit);
	wire q_mcast = is_mcast & (any_mc_en | (addr_en & addr_hit));
	wire q_bcast = is_bcast & bcast_en;
	wire addr_ok = q_ucast | q_mcast | q_bcast;
	wire crc_ok = crc_q == cfg_b_q;

	// End-of-frame decision, once per frame
	wire frame_end = rx_eof & in_frame_q;
	wire wake_hit = frame_end & wake_csr_en_q & filter_en & crc_ok & addr_ok & rx_fcs_ok & rx_len_ok;

	// Read mux
	// Unmapped words read as zero; reserved bits read as zero except in configuration A, which returns them as written
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = RST_ZERO;
		case (word_sel)
			OFS_WAKE_CSR[7:2]: begin
				rd_mux[CSR_DETECT_EN_BIT] = wake_csr_en_q;
				rd_mux[CSR_FRAME_RX_BIT] = wake_rx_flag_q;
			end
			OFS_CFG_A[7:2]: begin
				rd_mux = cfg_a_q;
				rd_mux[CFGA_TRIG_BIT] = trig_flag_q;
			end
			OFS_CFG_B[7:2]: rd_mux[15:0] = cfg_b_q;
			OFS_ADDR_A[7:2]: rd_mux[15:0] = addr_a_q;
			OFS_ADDR_B[7:2]: rd_mux[15:0] = addr_b_q;
			OFS_ADDR_C[7:2]: rd_mux[15:0] = addr_c_q;
			OFS_IRQ_MASK[7:2]: rd_mux[WAKE_EVENT_BIT] = irq_mask_q;
			OFS_IRQ_SRC[7:2]: rd_mux[WAKE_EVENT_BIT] = irq_src_q;
			default: begin
				if (mask_hit) begin
					rd_mux = mask_q[32*mask_idx +: 32];
				end
			end
		endcase
	end

	// Bus handshake: every access takes exactly one wait cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~acc;
		end
	end

	// Read data is latched at the accepting edge, so it stands while waitrequest is low
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= RST_ZERO;
		end else if (acc && avs_read) begin
			rdata_q <= rd_mux;
		end
	end

	// Software-written configuration, one register per process
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_csr_en_q <= 1'b0;
		end else if (wr_csr && avs_byteenable[0]) begin
			wake_csr_en_q <= avs_writedata[CSR_DETECT_EN_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_a_q <= RST_ZERO;
		end else if (wr_cfga) begin
			cfg_a_q <= be_merge(cfg_a_q, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_b_q <= 16'h0000;
		end else if (wr_cfgb) begin
			cfg_b_q <= 16'(be_merge({16'h0000, cfg_b_q}, avs_writedata, avs_byteenable));
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mask_q <= '0;
		end else if (wr_mask) begin
			mask_q[32*mask_idx +: 32] <= be_merge(mask_q[32*mask_idx +: 32], avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_a_q <= 16'h0000;
		end else if (wr_adra) begin
			addr_a_q <= 16'(be_merge({16'h0000, addr_a_q}, avs_writedata, avs_byteenable));
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_b_q <= 16'h0000;
		end else if (wr_adrb) begin
			addr_b_q <= 16'(be_merge({16'h0000, addr_b_q}, avs_writedata, avs_byteenable));
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			addr_c_q <= 16'h0000;
		end else if (wr_adrc) begin
			addr_c_q <= 16'(be_merge({16'h0000, addr_c_q}, avs_writedata, avs_byteenable));
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_mask_q <= 1'b0;
		end else if (wr_imask && avs_byteenable[1]) begin
			irq_mask_q <= avs_writedata[WAKE_EVENT_BIT];
		end
	end

	// Hardware-set flags, cleared by writing one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_rx_flag_q <= 1'b0;
		end else begin
			wake_rx_flag_q <= flag_next(wake_rx_flag_q, wake_hit, clr_rx_flag);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trig_flag_q <= 1'b0;
		end else begin
			trig_flag_q <= flag_next(trig_flag_q, wake_hit, clr_trig);
		end
	end

	wire src_next = flag_next(irq_src_q, wake_hit, clr_src);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_src_q <= 1'b0;
		end else begin
			irq_src_q <= src_next;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wake_ev_q <= 1'b0;
		end else begin
			wake_ev_q <= wake_hit;
		end
	end

	// Follows the source flag's next value, so it rises together with the wake pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= src_next & irq_mask_q;
		end
	end

	// Frame tracking; a second end marker without a new start is ignored
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_frame_q <= 1'b0;
		end else if (rx_eof) begin
			in_frame_q <= 1'b0;
		end else if (rx_valid && rx_sof) begin
			in_frame_q <= 1'b1;
		end
	end

	// Saturating, so an overlong frame cannot wrap back into the mask window
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (byte_ok) begin
			cnt_q <= cnt_nxt;
		end
	end

	// Destination address capture from the first six bytes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DA_BYTES; i++) begin
				da_q[i] <= 8'h00;
			end
		end else if (da_cap) begin
			da_q[pos[2:0]] <= rx_data;
		end
	end

	// Every output comes straight from a flip-flop
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign wake_event = wake_ev_q;
	assign xcvr_irq = irq_q;
endmodule // wfp_filter
`default_nettype wire

// ==== tb/wfp_filter_monitor.sv ====
// Checker of bus handshake, wake pulse and interrupt timing of the filter
`timescale 1ns/10ps
`default_nettype none
module wfp_filter_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic rx_eof,
	input wire logic rx_fcs_ok,
	input wire logic rx_len_ok,
	input wire logic wake_event,
	input wire logic xcvr_irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_bad_end;
		rx_eof && !(rx_fcs_ok && rx_len_ok);
	endsequence
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	chk_wake_cause: assert property (wake_event |-> $past(rx_eof && rx_fcs_ok && rx_len_ok))
		else $error("wake pulse without a good frame end");
	chk_bad_end: assert property (s_bad_end |=> !wake_event)
		else $error("wake pulse after a failed frame");
	chk_wake_pulse: assert property (wake_event |=> !wake_event)
		else $error("wake pulse longer than one cycle");
	chk_bus_answer: assert property (s_req |=> !avs_waitrequest)
		else $error("bus access not answered after one wait cycle");
	chk_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_bus_quiet: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer without a request");
	chk_irq_rise: assert property ($rose(xcvr_irq) |-> wake_event || $past(avs_write) || $past(avs_write, 2))
		else $error("interrupt rose without a wake or a write");
	chk_irq_fall: assert property ($fell(xcvr_irq) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("interrupt fell without a write");
endmodule // wfp_filter_monitor
bind wfp_filter wfp_filter_monitor i_mon (.core_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
	.rx_eof, .rx_fcs_ok, .rx_len_ok, .wake_event, .xcvr_irq);
`default_nettype wire

// ==== tb/wfp_rx_source.sv ====
// Receive datapath model that hands frame bytes and the end-of-frame verdict
`timescale 1ns/10ps
`default_nettype none
module wfp_rx_source (
	input wire logic core_clk,
	output logic rx_valid,
	output logic rx_sof,
	output logic [7:0] rx_data,
	output logic rx_eof,
	output logic rx_fcs_ok,
	output logic rx_len_ok
);
	logic [7:0] fb [0:255];
	integer seed = 7;
	initial begin
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		rx_data = 8'h00;
		rx_eof = 1'b0;
		rx_fcs_ok = 1'b0;
		rx_len_ok = 1'b0;
	end
	// Idle lines toggle so a stale byte or verdict is never taken for a live one
	task automatic idle();
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		rx_eof <= 1'b0;
		rx_data <= ~rx_data;
		rx_fcs_ok <= ~rx_fcs_ok;
		rx_len_ok <= ~rx_len_ok;
	endtask
	task automatic send(input int n, input logic fcs, input logic lok);
		for (int i = 0; i < n; i++) begin
			repeat ($unsigned($random(seed)) % 3) begin
				@(posedge core_clk);
				idle();
			end
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_data <= fb[i];
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		rx_data <= ~rx_data;
		rx_eof <= 1'b1;
		rx_fcs_ok <= fcs;
		rx_len_ok <= lok;
		@(posedge core_clk);
		idle();
	endtask
endmodule // wfp_rx_source
`default_nettype wire

// ==== tb/tb_wfp_filter.sv ====
// Self-checking bench of the wake frame pattern filter
`timescale 1ns/10ps
`default_nettype none
module tb_wfp_filter;
	import wfp_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata, rd, cfga, v;
	logic avs_waitrequest, rx_valid, rx_sof, rx_eof, rx_fcs_ok, rx_len_ok, wake_event, xcvr_irq;
	logic [7:0] rx_data;
	logic [127:0] mask;
	logic [47:0] pa;
	logic [15:0] crc;
	logic fen, det, fcs, lok, bad, aen, amc, bce, imk, bc, mc, am, wk;
	integer seed = 7;
	int fail_count = 0;
	int n_checks = 0;
	int ofs, len, r;
	wfp_filter i_wfp_filter (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_sof(rx_sof),
		.rx_data(rx_data), .rx_eof(rx_eof), .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok),
		.wake_event(wake_event), .xcvr_irq(xcvr_irq));
	wfp_rx_source i_src (.core_clk(core_clk), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_data(rx_data),
		.rx_eof(rx_eof), .rx_fcs_ok(rx_fcs_ok), .rx_len_ok(rx_len_ok));
	initial forever #10 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
		logic [7:0] f;
		f[0] = c[15] ^ d[0];
		for (int i = 1; i < 8; i++) f[i] = c[15-i] ^ f[i-1] ^ d[i];
		return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4],
			f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		bus(1'b0, OFS_WAKE_CSR, 32'h0);
		chk(rd, RST_ZERO);
		bus(1'b0, OFS_CFG_A, 32'h0);
		chk(rd, RST_ZERO);
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		bus(1'b0, 8'hFC, 32'h0);
		chk(rd, RST_ZERO);
		avs_byteenable <= 4'h1;
		bus(1'b1, OFS_CFG_B, 32'hFFFF_FFFF);
		avs_byteenable <= 4'hF;
		bus(1'b0, OFS_CFG_B, 32'h0);
		chk(rd, 32'h0000_00FF);
		for (int k = 0; k < 60; k++) begin
			ofs = $unsigned($random(seed)) % 24;
			len = ofs + 6 + $unsigned($random(seed)) % 140;
			mask = {$random(seed), $random(seed), $random(seed), $random(seed)};
			pa = 48'({$random(seed), $random(seed)});
			r = $unsigned($random(seed)) % 3;
			for (int i = 0; i < 256; i++) i_src.fb[i] = 8'($random(seed));
			for (int i = 0; i < 6; i++) if (r == 0) i_src.fb[i] = pa[8*i+:8]; else if (r == 1) i_src.fb[i] = 8'hFF;
			bc = 1'b1;
			am = 1'b1;
			for (int i = 0; i < 6; i++) begin
				bc &= (i_src.fb[i] == 8'hFF);
				am &= (i_src.fb[i] == pa[8*i+:8]);
			end
			mc = i_src.fb[0][0] && !bc;
			crc = CRC_INIT;
			for (int j = 0; j < 128; j++) if (mask[j] && ofs + j < len) crc = step(crc, i_src.fb[ofs + j]);
			v = $random(seed);
			{fen, det, fcs, lok, bad} = {|v[2:0], |v[5:3], |v[8:6], |v[11:9], &v[13:12]};
			{aen, amc, bce, imk} = v[17:14];
			wk = fen && det && !bad && fcs && lok && (bc ? bce : mc ? (amc || aen && am) : (!aen || am));
			for (int w = 0; w < 4; w++) bus(1'b1, OFS_MASK0 + 8'(4 * w), mask[32*w+:32]);
			bus(1'b1, OFS_CFG_B, {16'h0, crc ^ 16'(bad)});
			bus(1'b1, OFS_ADDR_A, {16'h0, pa[15:0]});
			bus(1'b1, OFS_ADDR_B, {16'h0, pa[31:16]});
			bus(1'b1, OFS_ADDR_C, {16'h0, pa[47:32]});
			cfga = {fen, 3'b0, 1'b0, aen, amc, bce, 16'h0, 8'(ofs)};
			bus(1'b1, OFS_CFG_A, (cfga & 32'h7FFF_FFFF) | 32'h0800_0000);
			bus(1'b1, OFS_CFG_A, cfga);
			bus(1'b1, OFS_WAKE_CSR, {30'h0, 1'b1, det});
			bus(1'b1, OFS_IRQ_MASK, 32'(imk) << 8);
			bus(1'b1, OFS_IRQ_SRC, 32'h0000_0100);
			i_src.send(len, fcs, lok);
			@(posedge core_clk);
			chk(32'(wake_event), 32'(wk));
			@(posedge core_clk);
			chk(32'(wake_event), 32'h0);
			bus(1'b0, OFS_WAKE_CSR, 32'h0);
			chk(rd, {30'h0, wk, det});
			bus(1'b0, OFS_CFG_A, 32'h0);
			chk(rd, cfga | (32'(wk) << 27));
			bus(1'b0, OFS_IRQ_SRC, 32'h0);
			chk(rd, 32'(wk) << 8);
			chk(32'(xcvr_irq), 32'(wk && imk));
		end
		summarize();
	end
endmodule // tb_wfp_filter
`default_nettype wire
